//--- include/mec_pkg.sv
// Purpose: Shared constants of the measurement enable configuration bank
// Assumes: 16-bit register port, registers at their printed addresses
// Notes:   Field positions and reset values live here only
`default_nettype none
package mec_pkg;
  // Register port widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int N_AIN  = 4;

  // Register addresses
  localparam logic [ADDR_W-1:0] UPPER_CELL_MEASURE_ENABLE_ADDR   = 16'h1809;
  localparam logic [ADDR_W-1:0] ANALOG_INPUT_MEASURE_CONFIG_ADDR = 16'h180A;

  // Upper-cell enable fields
  localparam int CELL16_MEASURE_ON_BIT = 0;
  localparam int CELL17_MEASURE_ON_BIT = 1;
  localparam logic [DATA_W-1:0] UPPER_CELL_WRITE_MASK  = 16'h0003;
  localparam logic [DATA_W-1:0] UPPER_CELL_RESET_VALUE = 16'h0000;

  // Analog-input config fields
  localparam int INPUT_ENABLE_LSB              = 0;
  localparam int ANALOG_INPUT3_MEASURE_ON_BIT  = 3;
  localparam int ABSOLUTE_INPUT_MEASURE_ON_BIT = 4;
  localparam int FAULT_RESULT_INVALIDATE_BIT   = 5;
  localparam int REFERENCE_SELECT_LSB          = 8;
  localparam int REFERENCE_SELECT_W            = 2;
  localparam logic [DATA_W-1:0] ANALOG_CONFIG_WRITE_MASK  = 16'hFF3F;
  localparam logic [DATA_W-1:0] ANALOG_CONFIG_RESET_VALUE = 16'h0020;

  // Reference selector codes
  typedef enum logic [1:0] {
    MEC_REF_INTERNAL  = 2'h0,
    MEC_REF_RESERVED  = 2'h1,
    MEC_REF_AUXILIARY = 2'h2,
    MEC_REF_CORE      = 2'h3
  } mec_ref_sel_t;

  // Sequencer channel numbers
  localparam int CHAN_W = 3;
  localparam logic [CHAN_W-1:0] CHAN_CELL16   = 3'h0;
  localparam logic [CHAN_W-1:0] CHAN_CELL17   = 3'h1;
  localparam logic [CHAN_W-1:0] CHAN_AIN0     = 3'h2;
  localparam logic [CHAN_W-1:0] CHAN_ABSOLUTE = 3'h6;
endpackage
`default_nettype wire

//--- rtl/mec_config_bank.sv
// Purpose: Measurement enable and analog-input configuration registers
// Assumes: Software port on the core clock, read data one cycle later
// Notes:   Gates sequencer channel requests and the shared GPIO output
//
// The plain strobed port was left to the implementer.
`default_nettype none
`timescale 1ns/10ps

// How it works
// RQ1 - Upper-cell enable register, 16 bits, at address 1809h.
// RQ2 - Bit 1 switches cell channel 17 into or out of measurement.
// RQ3 - Bit 0 switches cell channel 16 into or out of measurement.
// RQ4 - Both upper-cell enables clear to zero on reset.
// RQ5 - Upper-cell bits 15 to 2 read zero and ignore writes.
// RQ6 - Software leaves enables alone during a running measurement.
// RQ7 - Analog config at 180Ah: selectors, zero bits, invalidate, enables; resets 0020h.
// RQ8 - Selector: 00 internal, 10 auxiliary ratio, 11 core ratio, 01 reserved.
// RQ9 - Invalidate set marks analog results invalid on fault; clear keeps them valid.
// RQ10 - Input 3 enable forces GPIO output off; GPIO enable bit unchanged.
// RQ11 - Sequencer skips disabled channels and keeps their results.
module mec_config_bank
  import mec_pkg::*;
(
  // Clock and reset
  input  wire logic                            core_clk_in,
  input  wire logic                            rst_in,
  // Register port
  input  wire logic [mec_pkg::ADDR_W-1:0]      reg_addr_in,
  input  wire logic [mec_pkg::DATA_W-1:0]      reg_wdata_in,
  input  wire logic                            reg_write_in,
  input  wire logic                            reg_read_in,
  output logic      [mec_pkg::DATA_W-1:0]      reg_rdata_out,
  // Configuration to the measurement path
  output logic                                 cell16_measure_on_out,
  output logic                                 cell17_measure_on_out,
  output logic      [mec_pkg::N_AIN-1:0]       analog_input_measure_on_out,
  output logic                                 absolute_input_measure_on_out,
  output logic      [mec_pkg::N_AIN-1:0]       input_ratiometric_out,
  output logic      [mec_pkg::N_AIN-1:0]       input_core_reference_out,
  // Sequencer channel gating
  input  wire logic                            seq_request_in,
  input  wire logic [mec_pkg::CHAN_W-1:0]      seq_channel_in,
  output logic                                 seq_measure_out,
  output logic                                 seq_skip_out,
  // Fault handling of analog results
  input  wire logic                            fault_detected_in,
  output logic                                 analog_result_invalid_out,
  // Shared general-purpose pin, input 3
  input  wire logic                            gpio3_out_enable_in,
  output logic                                 gpio3_out_enable_out
);
  import mec_pkg::*;

  logic [DATA_W-1:0] upper_cell_measure_enable;
  logic [DATA_W-1:0] analog_input_measure_config;
  logic [DATA_W-1:0] next_rdata;
  logic              channel_enabled;
  logic              wr_upper;
  logic              wr_analog;

  // Address decode of the write strobe
  assign wr_upper  = reg_write_in && (reg_addr_in == UPPER_CELL_MEASURE_ENABLE_ADDR);
  assign wr_analog = reg_write_in && (reg_addr_in == ANALOG_INPUT_MEASURE_CONFIG_ADDR);

  // Upper-cell enable register; reserved bits never store
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      upper_cell_measure_enable <= UPPER_CELL_RESET_VALUE; // [RQ4]
    end else if (wr_upper) begin // [RQ1]
      upper_cell_measure_enable <= reg_wdata_in & UPPER_CELL_WRITE_MASK; // [RQ5]
    end
  end

  // Analog-input config register; bits 7:6 held at zero
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      analog_input_measure_config <= ANALOG_CONFIG_RESET_VALUE; // [RQ7]
    end else if (wr_analog) begin
      analog_input_measure_config <= reg_wdata_in & ANALOG_CONFIG_WRITE_MASK; // [RQ7]
    end
  end

  // Read mux; unmapped addresses answer zero
  always_comb begin
    next_rdata = '0;
    if (reg_read_in) begin
      case (reg_addr_in)
        UPPER_CELL_MEASURE_ENABLE_ADDR:   next_rdata = upper_cell_measure_enable; // [RQ5]
        ANALOG_INPUT_MEASURE_CONFIG_ADDR: next_rdata = analog_input_measure_config;
        default:                          next_rdata = '0;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= '0;
    end else begin
      reg_rdata_out <= next_rdata;
    end
  end

  // Enables straight from register bits
  assign cell16_measure_on_out = upper_cell_measure_enable[CELL16_MEASURE_ON_BIT]; // [RQ3]
  assign cell17_measure_on_out = upper_cell_measure_enable[CELL17_MEASURE_ON_BIT]; // [RQ2]
  assign absolute_input_measure_on_out =
    analog_input_measure_config[ABSOLUTE_INPUT_MEASURE_ON_BIT];

  // Per-input enable and reference decode; reserved code falls back to internal
  for (genvar i = 0; i < N_AIN; i++) begin : g_ain
    mec_ref_sel_t ref_sel;
    assign ref_sel = mec_ref_sel_t'(analog_input_measure_config[
      REFERENCE_SELECT_LSB + REFERENCE_SELECT_W*i +: REFERENCE_SELECT_W]);
    assign analog_input_measure_on_out[i] = analog_input_measure_config[INPUT_ENABLE_LSB + i];
    assign input_ratiometric_out[i]    = (ref_sel == MEC_REF_AUXILIARY) ||
                                         (ref_sel == MEC_REF_CORE); // [RQ8]
    assign input_core_reference_out[i] = (ref_sel == MEC_REF_CORE); // [RQ8]
  end

  // Enable of the channel the sequencer asks about
  always_comb begin
    channel_enabled = 1'b0;
    case (seq_channel_in)
      CHAN_CELL16:   channel_enabled = cell16_measure_on_out;
      CHAN_CELL17:   channel_enabled = cell17_measure_on_out;
      CHAN_ABSOLUTE: channel_enabled = absolute_input_measure_on_out;
      default: begin
        if (seq_channel_in >= CHAN_AIN0 && seq_channel_in < CHAN_ABSOLUTE) begin
          channel_enabled = analog_input_measure_on_out[
            2'(seq_channel_in - CHAN_AIN0)];
        end
      end
    endcase
  end

  // Grant or skip, one pulse per request; skip keeps the old result
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      seq_measure_out <= 1'b0;
      seq_skip_out    <= 1'b0;
    end else begin
      seq_measure_out <= seq_request_in && channel_enabled;  // [RQ11]
      seq_skip_out    <= seq_request_in && !channel_enabled; // [RQ11]
    end
  end

  // Fault marks analog results invalid only while invalidation is on
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      analog_result_invalid_out <= 1'b0;
    end else begin
      analog_result_invalid_out <= fault_detected_in &&
        analog_input_measure_config[FAULT_RESULT_INVALIDATE_BIT]; // [RQ9]
    end
  end

  // Measuring input 3 wins the shared pin; the GPIO enable register is untouched
  assign gpio3_out_enable_out = gpio3_out_enable_in &&
    !analog_input_measure_config[ANALOG_INPUT3_MEASURE_ON_BIT]; // [RQ10]

  // Writes during a running measurement are accepted as is; the caller avoids them [RQ6]

  // Checks
  a_upper_write_lands: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RQ1]
    wr_upper |=> upper_cell_measure_enable == ($past(reg_wdata_in) & UPPER_CELL_WRITE_MASK))
    else $error("upper-cell enable write not stored");
  a_cell17_follows: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RQ2]
    wr_upper |=> cell17_measure_on_out == $past(reg_wdata_in[CELL17_MEASURE_ON_BIT]))
    else $error("cell 17 enable does not follow write");
  a_cell16_follows: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RQ3]
    wr_upper |=> cell16_measure_on_out == $past(reg_wdata_in[CELL16_MEASURE_ON_BIT]))
    else $error("cell 16 enable does not follow write");
  a_upper_reset_zero: assert property (@(posedge core_clk_in) // [RQ4]
    $fell(rst_in) |-> !cell16_measure_on_out && !cell17_measure_on_out)
    else $error("upper-cell enables not zero after reset");
  a_upper_reserved_zero: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RQ5]
    reg_read_in && reg_addr_in == UPPER_CELL_MEASURE_ENABLE_ADDR
      |=> (reg_rdata_out & ~UPPER_CELL_WRITE_MASK) == '0)
    else $error("upper-cell reserved bits read nonzero");
  a_analog_readback: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RQ7]
    wr_analog ##1 (reg_read_in && reg_addr_in == ANALOG_INPUT_MEASURE_CONFIG_ADDR && !wr_analog)
      |=> reg_rdata_out == ($past(reg_wdata_in, 2) & ANALOG_CONFIG_WRITE_MASK))
    else $error("analog config readback mismatch");
  a_analog_reset_val: assert property (@(posedge core_clk_in) // [RQ7]
    $fell(rst_in) |-> analog_input_measure_config == ANALOG_CONFIG_RESET_VALUE)
    else $error("analog config reset value wrong");
  a_reference_decode: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RQ8]
    input_core_reference_out[0] |-> input_ratiometric_out[0] &&
      analog_input_measure_config[REFERENCE_SELECT_LSB +: REFERENCE_SELECT_W] == MEC_REF_CORE)
    else $error("reference decode wrong for input 0");
  a_fault_invalidate: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RQ9]
    fault_detected_in && analog_input_measure_config[FAULT_RESULT_INVALIDATE_BIT] && !wr_analog
      |=> analog_result_invalid_out)
    else $error("fault did not invalidate analog results");
  a_fault_kept_valid: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RQ9]
    !analog_input_measure_config[FAULT_RESULT_INVALIDATE_BIT] && !wr_analog
      |=> !analog_result_invalid_out)
    else $error("results invalidated while invalidation off");
  a_gpio_forced_off: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RQ10]
    analog_input_measure_on_out[3] |-> !gpio3_out_enable_out)
    else $error("GPIO output on while input 3 measured");
  a_skip_disabled: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RQ11]
    seq_request_in && seq_channel_in == CHAN_CELL17 && !cell17_measure_on_out
      |=> seq_skip_out && !seq_measure_out)
    else $error("disabled cell 17 was not skipped");
  a_unmapped_zero: assert property (@(posedge core_clk_in) disable iff (rst_in)
    reg_read_in && reg_addr_in != UPPER_CELL_MEASURE_ENABLE_ADDR
      && reg_addr_in != ANALOG_INPUT_MEASURE_CONFIG_ADDR |=> reg_rdata_out == '0)
    else $error("unmapped read not zero");

  // Read data must not linger; a stale word would look like a fresh answer
  a_rdata_idle_zero: assert property (@(posedge core_clk_in) disable iff (rst_in)
    !reg_read_in |=> reg_rdata_out == '0)
    else $error("read data present without a read");

  // Readback of the upper-cell enables returns the stored word
  a_upper_readback: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RQ1]
    reg_read_in && reg_addr_in == UPPER_CELL_MEASURE_ENABLE_ADDR
      |=> reg_rdata_out == $past(upper_cell_measure_enable))
    else $error("upper-cell enable readback mismatch");

  // Only a decoded write may change the upper-cell enables
  a_upper_holds: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RQ1]
    !wr_upper |=> $stable(upper_cell_measure_enable))
    else $error("upper-cell enables changed without a write");

  // Reserved upper-cell bits never hold a one, whatever was written
  a_upper_store_masked: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RQ5]
    (upper_cell_measure_enable & ~UPPER_CELL_WRITE_MASK) == '0)
    else $error("reserved upper-cell bit stored");

  // Only a decoded write may change the analog config
  a_analog_holds: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RQ7]
    !wr_analog |=> $stable(analog_input_measure_config))
    else $error("analog config changed without a write");

  // Bits 7:6 of the analog config stay zero in storage
  a_analog_reserved_zero: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RQ7]
    (analog_input_measure_config & ~ANALOG_CONFIG_WRITE_MASK) == '0)
    else $error("reserved analog config bit stored");

  // Input enables follow the low field of a write
  a_inputs_follow: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RQ7]
    wr_analog |=> analog_input_measure_on_out == $past(reg_wdata_in[INPUT_ENABLE_LSB +: N_AIN]))
    else $error("input enables do not follow write");

  // Absolute-input enable follows its write bit
  a_absolute_follows: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RQ7]
    wr_analog |=> absolute_input_measure_on_out == $past(reg_wdata_in[ABSOLUTE_INPUT_MEASURE_ON_BIT]))
    else $error("absolute input enable does not follow write");

  // Invalidation comes out of reset switched on
  a_invalidate_reset_on: assert property (@(posedge core_clk_in) // [RQ9]
    $fell(rst_in) |-> analog_input_measure_config[FAULT_RESULT_INVALIDATE_BIT])
    else $error("invalidate control not set after reset");

  // Auxiliary code gives ratiometric without the core supply
  a_reference_aux: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RQ8]
    input_ratiometric_out[0] && !input_core_reference_out[0] |->
      analog_input_measure_config[REFERENCE_SELECT_LSB +: REFERENCE_SELECT_W] == MEC_REF_AUXILIARY)
    else $error("auxiliary reference decode wrong for input 0");

  // Upper selector bit clear means the internal reference; reserved code included
  a_reference_internal: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RQ8]
    !analog_input_measure_config[REFERENCE_SELECT_LSB + 1] |->
      !input_ratiometric_out[0] && !input_core_reference_out[0])
    else $error("internal reference decode wrong for input 0");

  // Highest input uses the top selector field
  a_reference_core3: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RQ8]
    input_core_reference_out[3] |-> &analog_input_measure_config[
      REFERENCE_SELECT_LSB + REFERENCE_SELECT_W*(N_AIN-1) +: REFERENCE_SELECT_W])
    else $error("reference decode wrong for input 3");

  // No fault, no invalidation, whatever the control says
  a_fault_needed: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RQ9]
    !fault_detected_in |=> !analog_result_invalid_out)
    else $error("results invalidated without a fault");

  // With input 3 off the GPIO enable passes untouched
  a_gpio_passes: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RQ10]
    !analog_input_measure_config[ANALOG_INPUT3_MEASURE_ON_BIT] |->
      gpio3_out_enable_out == gpio3_out_enable_in)
    else $error("GPIO output enable altered while input 3 off");

  // Every request gets exactly one of the two answers
  a_seq_one_answer: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RQ11]
    seq_request_in |=> seq_measure_out != seq_skip_out)
    else $error("sequencer request without a single answer");

  // No request, no answer
  a_seq_quiet: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RQ11]
    !seq_request_in |=> !seq_measure_out && !seq_skip_out)
    else $error("sequencer answer without a request");

  // Enabled cell 16 is measured
  a_cell16_measured: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RQ11]
    seq_request_in && seq_channel_in == CHAN_CELL16 && cell16_measure_on_out
      |=> seq_measure_out && !seq_skip_out)
    else $error("enabled cell 16 was not measured");

  // Input 0 is gated by its own enable
  a_input0_gated: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RQ11]
    seq_request_in && seq_channel_in == CHAN_AIN0
      |=> seq_measure_out == $past(analog_input_measure_on_out[0]))
    else $error("input 0 gating wrong");

  // Absolute input is gated by its own enable
  a_absolute_gated: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RQ11]
    seq_request_in && seq_channel_in == CHAN_ABSOLUTE
      |=> seq_measure_out == $past(absolute_input_measure_on_out))
    else $error("absolute input gating wrong");

  // The spare channel number names nothing and is always skipped
  a_spare_skipped: assert property (@(posedge core_clk_in) disable iff (rst_in) // [RQ11]
    seq_request_in && (&seq_channel_in) |=> seq_skip_out && !seq_measure_out)
    else $error("spare channel was not skipped");

  // Main scenarios
  c_cell17_measured: cover property (@(posedge core_clk_in) disable iff (rst_in)
    wr_upper ##1 seq_request_in && seq_channel_in == CHAN_CELL17 ##1 seq_measure_out);
  c_input3_takes_pin: cover property (@(posedge core_clk_in) disable iff (rst_in)
    gpio3_out_enable_in && analog_input_measure_on_out[3]);
  c_fault_invalidates: cover property (@(posedge core_clk_in) disable iff (rst_in)
    fault_detected_in ##1 analog_result_invalid_out);
  c_core_reference: cover property (@(posedge core_clk_in) disable iff (rst_in)
    input_core_reference_out[3]);
  c_write_then_read: cover property (@(posedge core_clk_in) disable iff (rst_in)
    wr_analog ##1 reg_read_in && reg_addr_in == ANALOG_INPUT_MEASURE_CONFIG_ADDR);

endmodule // mec_config_bank
`default_nettype wire

//--- verification/test_mec_config_bank.sv
// Purpose: Self-checking bench for the measurement enable configuration bank
// Assumes: Read data and sequencer answers come exactly one cycle after the strobe
// Notes:   Driver queues expected answers; a monitor pops them as they appear
`timescale 1ns/10ps
`default_nettype none
module test_mec_config_bank;
  import mec_pkg::*;
  // Stimulus and observed signals
  logic                 core_clk_in         = 1'b0;
  logic                 rst_in              = 1'b1;
  logic [ADDR_W-1:0]    reg_addr_in         = '0;
  logic [DATA_W-1:0]    reg_wdata_in        = '0;
  logic                 reg_write_in        = 1'b0;
  logic                 reg_read_in         = 1'b0;
  logic                 seq_request_in      = 1'b0;
  logic [CHAN_W-1:0]    seq_channel_in      = '0;
  logic                 fault_detected_in   = 1'b0;
  logic                 gpio3_out_enable_in = 1'b0;
  logic [DATA_W-1:0]    reg_rdata_out;
  logic                 cell16_on, cell17_on, abs_on, seq_measure, seq_skip, res_invalid, gpio_oe;
  logic [N_AIN-1:0]     ain_on, ratio, core_ref;
  logic [15:0]          rd_q[$], sq_q[$];
  logic                 rd_seen = 1'b0, sq_seen = 1'b0;
  logic [31:0]          rnd = 32'h780e_700c;
  logic [7:0]           en;
  int                   miscompares = 0, samples_checked = 0;

  mec_config_bank u_mec_config_bank (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
    .reg_rdata_out(reg_rdata_out), .cell16_measure_on_out(cell16_on),
    .cell17_measure_on_out(cell17_on), .analog_input_measure_on_out(ain_on),
    .absolute_input_measure_on_out(abs_on), .input_ratiometric_out(ratio),
    .input_core_reference_out(core_ref), .seq_request_in(seq_request_in),
    .seq_channel_in(seq_channel_in), .seq_measure_out(seq_measure), .seq_skip_out(seq_skip),
    .fault_detected_in(fault_detected_in), .analog_result_invalid_out(res_invalid),
    .gpio3_out_enable_in(gpio3_out_enable_in), .gpio3_out_enable_out(gpio_oe));

  // Free-running core clock
  always #5 core_clk_in = ~core_clk_in;

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // wr and rd set both register strobes, so back-to-back calls never drive one signal twice
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    reg_read_in  <= 1'b0;
    @(posedge core_clk_in);
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    rd_q.push_back(e);
    reg_addr_in  <= a;
    reg_read_in  <= 1'b1;
    reg_write_in <= 1'b0;
    @(posedge core_clk_in);
  endtask
  task automatic sq(input logic [2:0] ch, input logic [15:0] e);
    sq_q.push_back(e);
    seq_channel_in <= ch;
    seq_request_in <= 1'b1;
    @(posedge core_clk_in);
  endtask
  task automatic idle();
    reg_write_in   <= 1'b0;
    reg_read_in    <= 1'b0;
    seq_request_in <= 1'b0;
    @(posedge core_clk_in);
  endtask

  // Answers are compared mid-cycle, clear of the launching edge
  always @(posedge core_clk_in) begin
    rd_seen <= reg_read_in;
    sq_seen <= seq_request_in;
  end
  always @(negedge core_clk_in) begin
    if (rd_seen) check(reg_rdata_out, rd_q.pop_front());
    if (sq_seen) check({14'h0, seq_skip, seq_measure}, sq_q.pop_front());
  end

  // Watchdog, far beyond the some 160 cycles the tests need
  initial begin
    #50000;
    miscompares++;
    summarize();
  end

  initial begin
    repeat (3) @(posedge core_clk_in);
    rst_in <= 1'b0;
    rd(UPPER_CELL_MEASURE_ENABLE_ADDR, 16'h0000);
    rd(ANALOG_INPUT_MEASURE_CONFIG_ADDR, 16'h0020);
    idle();
    $display("test reset values done");
    // Random contents, read back at once; outputs and channel gating follow
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr_next(rnd);
      gpio3_out_enable_in <= rnd[24];
      wr(UPPER_CELL_MEASURE_ENABLE_ADDR, rnd[15:0]);
      rd(UPPER_CELL_MEASURE_ENABLE_ADDR, rnd[15:0] & 16'h0003);
      wr(ANALOG_INPUT_MEASURE_CONFIG_ADDR, rnd[31:16]);
      rd(ANALOG_INPUT_MEASURE_CONFIG_ADDR, rnd[31:16] & 16'hFF3F);
      idle();
      @(negedge core_clk_in);
      check({14'h0, cell17_on, cell16_on}, {14'h0, rnd[1:0]});
      check({11'h0, abs_on, ain_on}, {11'h0, rnd[20:16]});
      check({15'h0, gpio_oe}, {15'h0, rnd[24] & ~rnd[19]});
      @(posedge core_clk_in);
      // Enables stay put while the sequencer asks
      en = {1'b0, rnd[20:16], rnd[1:0]};
      for (int ch = 0; ch < 8; ch++) sq(ch[2:0], {14'h0, ~en[ch], en[ch]});
      idle();
    end
    // Unmapped neighbours are ignored and read zero
    wr(16'h180B, 16'hFFFF);
    rd(16'h180B, 16'h0000);
    rd(16'h1808, 16'h0000);
    rd(UPPER_CELL_MEASURE_ENABLE_ADDR, rnd[15:0] & 16'h0003);
    idle();
    $display("test random contents done");
    // Every selector code on all four inputs, reserved code included
    for (int c = 0; c < 4; c++) begin
      wr(ANALOG_INPUT_MEASURE_CONFIG_ADDR, {{4{c[1:0]}}, 8'h00});
      rd(ANALOG_INPUT_MEASURE_CONFIG_ADDR, {{4{c[1:0]}}, 8'h00});
      idle();
      @(negedge core_clk_in);
      check({12'h0, ratio}, {12'h0, {4{c[1]}}});
      check({12'h0, core_ref}, {12'h0, {4{c == 3}}});
      @(posedge core_clk_in);
    end
    $display("test reference select done");
    // Fault with invalidate off then on, then fault removed
    for (int v = 0; v < 2; v++) begin
      wr(ANALOG_INPUT_MEASURE_CONFIG_ADDR, {10'h0, v[0], 5'h0});
      fault_detected_in <= 1'b1;
      idle();
      @(negedge core_clk_in);
      check({15'h0, res_invalid}, {15'h0, v[0]});
      @(posedge core_clk_in);
      fault_detected_in <= 1'b0;
      idle();
      @(negedge core_clk_in);
      check({15'h0, res_invalid}, 16'h0000);
      @(posedge core_clk_in);
    end
    $display("test fault invalidate done");
    summarize();
  end
endmodule // test_mec_config_bank
`default_nettype wire
